/* File: rtl/pid_pkg.sv */
// Purpose: Shared constants and types for the pulse input decoder.
// Assumes: One 250 MHz clock, synchronous active-high reset.
// Notes: Speed limits are expressed as minimum cycles between counted edges.
package pid_pkg;
   localparam int unsigned CLK_HZ = 250000000;
   localparam int unsigned SPD_10K_PPS = 10000;
   localparam int unsigned SPD_50K_PPS = 50000;
   localparam int unsigned SPD_100K_PPS = 100000;
   localparam int unsigned SPD_200K_PPS = 200000;
   localparam int unsigned GAP_10K = CLK_HZ / SPD_10K_PPS;
   localparam int unsigned GAP_50K = CLK_HZ / SPD_50K_PPS;
   localparam int unsigned GAP_100K = CLK_HZ / SPD_100K_PPS;
   localparam int unsigned GAP_200K = CLK_HZ / SPD_200K_PPS;
   localparam int GAP_W = 16;

   typedef enum logic [3:0] {
      PID_SRC_AB = 4'h0,
      PID_SRC_INT_0U1 = 4'h1,
      PID_SRC_INT_1U = 4'h2,
      PID_SRC_INT_10U = 4'h3,
      PID_SRC_INT_100U = 4'h4,
      PID_SRC_OTHER_CH = 4'h5
   } pid_src_e;

   typedef enum logic [3:0] {
      PID_MODE_1P_X1 = 4'h0,
      PID_MODE_1P_X1_A = 4'h1,
      PID_MODE_1P_X2 = 4'h2,
      PID_MODE_1P_X2_A = 4'h3,
      PID_MODE_UP_DOWN_PAIR = 4'h4,
      PID_MODE_2P_X1 = 4'h5,
      PID_MODE_2P_X2 = 4'h6,
      PID_MODE_2P_X4 = 4'h7
   } pid_mode_e;

   typedef enum logic [1:0] {
      PID_SPD_10K = 2'h0,
      PID_SPD_50K = 2'h1,
      PID_SPD_100K = 2'h2,
      PID_SPD_200K = 2'h3
   } pid_spd_e;

   typedef struct packed {
      logic a;
      logic b;
      logic z;
      logic func;
      logic latch;
   } pid_pins_s;

   typedef struct packed {
      logic up;
      logic down;
   } pid_strobe_s;
endpackage

/* File: rtl/pid_edge.sv */
// Purpose: Registers one input and reports its rising and falling edges.
// Assumes: Input already synchronous to the clock.
// Notes: Edge outputs are combinational against the held previous value.
`timescale 1ns/10ps
module pid_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic prev,
   output logic rise,
   output logic fall
);
   logic next_prev;

   always_comb begin
      next_prev = din;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   assign rise = din & ~prev;
   assign fall = ~din & prev;
endmodule // pid_edge

/* File: rtl/pid_top.sv */
// Purpose: Turns pulse inputs A and B into count-up and count-down strobes.
// Assumes: Pins synchronous to SYS_CLK; settings held steady while counting.
// Notes: Edges closer than the selected speed gap are dropped.
`timescale 1ns/10ps
// Function
// - Pair mode: A rise up, B rise down.
// - 2-phase x1: A rise/fall with B low.
// - 2-phase x2 up on A edges.
// - 2-phase x2 down on A edges.
// - 2-phase x4 up on A, B edges.
// - 2-phase x4 down on A, B edges.
// - A-only modes ignore input B.
// - 10k and 50k allowed everywhere.
// - 100k refused in 2-phase x1.
// - 200k only in x2 1-phase, x4.
// - Normal mode signal set passed through.
// - Mode applies only with A/B source.
// - Unused inputs released as general input.
module pid_top (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire pid_pkg::pid_pins_s PINS,
   input wire pid_pkg::pid_src_e SRC,
   input wire pid_pkg::pid_mode_e MODE,
   input wire pid_pkg::pid_spd_e SPEED,
   input wire logic DOWN_CMD,
   input wire logic INT_TICK,
   input wire logic OTHER_MATCH,
   output pid_pkg::pid_strobe_s STROBE,
   output logic SPEED_ERR,
   output logic INDEX,
   output logic FUNC_IN,
   output logic LATCH_IN,
   output logic GP_A,
   output logic GP_B,
   output logic GP_A_VALID,
   output logic GP_B_VALID
);
   logic a_rise, a_fall;
   logic b_rise, b_fall;
   logic m_rise;
   logic a, b;
   logic raw_up, raw_down;
   logic speed_ok;
   logic [pid_pkg::GAP_W-1:0] gap, next_gap, gap_lim;
   pid_pkg::pid_strobe_s next_strobe;
   logic next_err, next_index, next_func, next_latch;
   logic next_gpa, next_gpb, next_gpa_v, next_gpb_v;

   function automatic logic a_only(input pid_pkg::pid_mode_e m);
      a_only = (m == pid_pkg::PID_MODE_1P_X1_A) || (m == pid_pkg::PID_MODE_1P_X2_A);
   endfunction

   function automatic logic spd_allowed(input pid_pkg::pid_mode_e m,
                                        input pid_pkg::pid_spd_e s);
      unique case (s)
         pid_pkg::PID_SPD_10K: spd_allowed = 1'b1;
         pid_pkg::PID_SPD_50K: spd_allowed = 1'b1;
         pid_pkg::PID_SPD_100K: spd_allowed = (m != pid_pkg::PID_MODE_2P_X1);
         pid_pkg::PID_SPD_200K: spd_allowed = (m == pid_pkg::PID_MODE_1P_X2) ||
            (m == pid_pkg::PID_MODE_1P_X2_A) || (m == pid_pkg::PID_MODE_2P_X4);
      endcase
   endfunction

   assign a = PINS.a;
   assign b = PINS.b;

   pid_edge u_edge_a (.clk(SYS_CLK), .rst(RESET), .din(a),
      .prev(), .rise(a_rise), .fall(a_fall));
   pid_edge u_edge_b (.clk(SYS_CLK), .rst(RESET), .din(b),
      .prev(), .rise(b_rise), .fall(b_fall));
   pid_edge u_edge_m (.clk(SYS_CLK), .rst(RESET), .din(OTHER_MATCH),
      .prev(), .rise(m_rise), .fall());

   always_comb begin
      raw_up = 1'b0;
      raw_down = 1'b0;
      unique case (MODE)
         pid_pkg::PID_MODE_UP_DOWN_PAIR: begin
            raw_up = a_rise & ~b;
            raw_down = b_rise & ~a;
         end
         pid_pkg::PID_MODE_2P_X1: begin
            raw_up = a_rise & ~b;
            raw_down = a_fall & ~b;
         end
         pid_pkg::PID_MODE_2P_X2: begin
            raw_up = (a_rise & ~b) | (a_fall & b);
            raw_down = (a_rise & b) | (a_fall & ~b);
         end
         pid_pkg::PID_MODE_2P_X4: begin
            raw_up = (a_rise & ~b) | (a_fall & b)
               | (b_rise & a) | (b_fall & ~a);
            raw_down = (a_rise & b) | (a_fall & ~b)
               | (b_rise & ~a) | (b_fall & a);
         end
         pid_pkg::PID_MODE_1P_X1: begin
            raw_up = a_rise & ~b & ~DOWN_CMD;
            raw_down = a_fall & (b | DOWN_CMD);
         end
         pid_pkg::PID_MODE_1P_X1_A: begin
            raw_up = a_rise & ~DOWN_CMD;
            raw_down = a_fall & DOWN_CMD;
         end
         pid_pkg::PID_MODE_1P_X2: begin
            raw_up = (a_rise | a_fall) & ~b & ~DOWN_CMD;
            raw_down = (a_rise | a_fall) & (b | DOWN_CMD);
         end
         pid_pkg::PID_MODE_1P_X2_A: begin
            raw_up = (a_rise | a_fall) & ~DOWN_CMD;
            raw_down = (a_rise | a_fall) & DOWN_CMD;
         end
         default: begin
            raw_up = 1'b0;
            raw_down = 1'b0;
         end
      endcase
   end

   always_comb begin
      unique case (SPEED)
         pid_pkg::PID_SPD_10K: gap_lim = pid_pkg::GAP_W'(pid_pkg::GAP_10K);
         pid_pkg::PID_SPD_50K: gap_lim = pid_pkg::GAP_W'(pid_pkg::GAP_50K);
         pid_pkg::PID_SPD_100K: gap_lim = pid_pkg::GAP_W'(pid_pkg::GAP_100K);
         pid_pkg::PID_SPD_200K: gap_lim = pid_pkg::GAP_W'(pid_pkg::GAP_200K);
      endcase
   end

   always_comb begin
      logic up, down, pass;
      up = 1'b0;
      down = 1'b0;
      pass = 1'b0;
      speed_ok = spd_allowed(MODE, SPEED);
      unique case (SRC)
         pid_pkg::PID_SRC_AB: begin
            up = raw_up;
            down = raw_down;
         end
         pid_pkg::PID_SRC_OTHER_CH: begin
            up = m_rise;
            down = 1'b0;
         end
         default: begin
            up = INT_TICK;
            down = 1'b0;
         end
      endcase
      pass = (SRC != pid_pkg::PID_SRC_AB) || (speed_ok && (gap >= gap_lim));
      next_gap = gap;
      if (gap < gap_lim) begin
         next_gap = gap + pid_pkg::GAP_W'(1);
      end
      if ((up ^ down) && pass) begin
         next_gap = '0;
      end
      next_strobe.up = up & ~down & pass;
      next_strobe.down = down & ~up & pass;
      next_err = (SRC == pid_pkg::PID_SRC_AB) && !speed_ok;
      next_index = PINS.z;
      next_func = PINS.func;
      next_latch = PINS.latch;
      next_gpa = a;
      next_gpb = b;
      next_gpa_v = (SRC != pid_pkg::PID_SRC_AB);
      next_gpb_v = (SRC != pid_pkg::PID_SRC_AB) || a_only(MODE);
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         gap <= '0;
         STROBE <= '0;
         SPEED_ERR <= 1'b0;
         INDEX <= 1'b0;
         FUNC_IN <= 1'b0;
         LATCH_IN <= 1'b0;
         GP_A <= 1'b0;
         GP_B <= 1'b0;
         GP_A_VALID <= 1'b0;
         GP_B_VALID <= 1'b0;
      end else begin
         gap <= next_gap;
         STROBE <= next_strobe;
         SPEED_ERR <= next_err;
         INDEX <= next_index;
         FUNC_IN <= next_func;
         LATCH_IN <= next_latch;
         GP_A <= next_gpa;
         GP_B <= next_gpb;
         GP_A_VALID <= next_gpa_v;
         GP_B_VALID <= next_gpb_v;
      end
   end

   property p_pair_up;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_UP_DOWN_PAIR && speed_ok &&
       gap >= gap_lim && a_rise && !b && !b_rise) |=> STROBE.up;
   endproperty
   a_pair_up: assert property (p_pair_up) else $error("pair up missed");

   property p_x1_down;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_2P_X1 && speed_ok &&
       gap >= gap_lim && a_fall && !b) |=> STROBE.down;
   endproperty
   a_x1_down: assert property (p_x1_down) else $error("x1 down missed");

   property p_x2_up;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_2P_X2 && speed_ok &&
       gap >= gap_lim && a_fall && b) |=> STROBE.up && !STROBE.down;
   endproperty
   a_x2_up: assert property (p_x2_up) else $error("x2 up missed");

   property p_x2_down;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_2P_X2 && speed_ok &&
       gap >= gap_lim && a_rise && b) |=> STROBE.down;
   endproperty
   a_x2_down: assert property (p_x2_down) else $error("x2 down missed");

   property p_x4_b;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_2P_X4 && speed_ok &&
       gap >= gap_lim && b_rise && !a_rise && !a_fall) |=> (STROBE.up == $past(a));
   endproperty
   a_x4_b: assert property (p_x4_b) else $error("x4 B edge wrong direction");

   property p_one_dir;
      @(posedge SYS_CLK) disable iff (RESET)
      !(STROBE.up && STROBE.down);
   endproperty
   a_one_dir: assert property (p_one_dir) else $error("both strobes high");

   property p_gap;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && $stable(SRC) && (STROBE.up || STROBE.down)) |=>
      !(STROBE.up || STROBE.down);
   endproperty
   a_gap: assert property (p_gap) else $error("strobes back to back");

   property p_err;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_2P_X1 &&
       SPEED == pid_pkg::PID_SPD_100K) |=> SPEED_ERR && !STROBE.up && !STROBE.down;
   endproperty
   a_err: assert property (p_err) else $error("100k accepted in x1");

   property p_aonly;
      @(posedge SYS_CLK) disable iff (RESET)
      (MODE == pid_pkg::PID_MODE_1P_X2_A && SRC == pid_pkg::PID_SRC_AB) |=> GP_B_VALID;
   endproperty
   a_aonly: assert property (p_aonly) else $error("B not released");

   property p_x4_a_up;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_2P_X4 && speed_ok &&
       gap >= gap_lim && a_fall && b && !b_rise && !b_fall) |=> STROBE.up && !STROBE.down;
   endproperty
   a_x4_a_up: assert property (p_x4_a_up) else $error("x4 A fall up missed");

   property p_x4_b_down;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && MODE == pid_pkg::PID_MODE_2P_X4 && speed_ok &&
       gap >= gap_lim && b_fall && a && !a_rise && !a_fall) |=> STROBE.down && !STROBE.up;
   endproperty
   a_x4_b_down: assert property (p_x4_b_down) else $error("x4 B fall down missed");

   property p_spd_200;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC == pid_pkg::PID_SRC_AB && SPEED == pid_pkg::PID_SPD_200K &&
       MODE != pid_pkg::PID_MODE_1P_X2 && MODE != pid_pkg::PID_MODE_1P_X2_A &&
       MODE != pid_pkg::PID_MODE_2P_X4) |=> SPEED_ERR && !STROBE.up && !STROBE.down;
   endproperty
   a_spd_200: assert property (p_spd_200) else $error("200k accepted in wrong mode");

   property p_low_speeds;
      @(posedge SYS_CLK) disable iff (RESET)
      (SPEED == pid_pkg::PID_SPD_10K || SPEED == pid_pkg::PID_SPD_50K) |=> !SPEED_ERR;
   endproperty
   a_low_speeds: assert property (p_low_speeds) else $error("low speed refused");

   property p_pass_side;
      @(posedge SYS_CLK) disable iff (RESET)
      1'b1 |=> INDEX == $past(PINS.z) && FUNC_IN == $past(PINS.func) &&
      LATCH_IN == $past(PINS.latch);
   endproperty
   a_pass_side: assert property (p_pass_side) else $error("side inputs not passed");

   property p_src_up;
      @(posedge SYS_CLK) disable iff (RESET)
      ((SRC == pid_pkg::PID_SRC_OTHER_CH && m_rise) ||
       (SRC != pid_pkg::PID_SRC_AB && SRC != pid_pkg::PID_SRC_OTHER_CH && INT_TICK)) |=>
      STROBE.up;
   endproperty
   a_src_up: assert property (p_src_up) else $error("source count missed");

   property p_src_down;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC != pid_pkg::PID_SRC_AB) |=> !STROBE.down;
   endproperty
   a_src_down: assert property (p_src_down) else $error("mode used off A/B source");

   property p_gp_release;
      @(posedge SYS_CLK) disable iff (RESET)
      (SRC != pid_pkg::PID_SRC_AB) |=> GP_A_VALID && GP_B_VALID && GP_A == $past(a);
   endproperty
   a_gp_release: assert property (p_gp_release) else $error("inputs not released");
endmodule // pid_top

/* File: tb/pid_enc.sv */
// Purpose: Encoder model that drives pulse inputs A and B and the side inputs.
// Assumes: Levels change one fixed delay after the rising clock edge.
// Notes: A and B move one phase step at a time, as a real encoder does.
`timescale 1ns/10ps
module pid_enc (
   input wire logic clk,
   output pid_pkg::pid_pins_s pins
);
   initial begin
      pins = '0;
   end
   // Toggles A or B and sets index, function and latch levels.
   task automatic step(input logic on_b, input logic [2:0] side);
      @(posedge clk);
      #1;
      if (on_b) begin
         pins.b = ~pins.b;
      end else begin
         pins.a = ~pins.a;
      end
      {pins.z, pins.func, pins.latch} = side;
   endtask
endmodule // pid_enc

/* File: tb/test_pid_top.sv */
// Purpose: Self-checking bench for the pulse input decoder.
// Assumes: Encoder model drives the pins; expected strobes queue up.
// Notes: Waits after each edge in run exceed the selected speed gap.
`timescale 1ns/10ps
module test_pid_top;
   logic SYS_CLK;
   logic RESET;
   pid_pkg::pid_pins_s pins;
   pid_pkg::pid_src_e src;
   pid_pkg::pid_mode_e mode;
   pid_pkg::pid_spd_e spd;
   pid_pkg::pid_strobe_s stb;
   pid_pkg::pid_strobe_s q[$];
   pid_pkg::pid_pins_s p;
   logic dcmd, tick, om, serr, idx, fin, lin, gpa, gpb, gpav, gpbv;
   int fail_count = 0;
   int cmp_count = 0;
   pid_enc enc (.clk(SYS_CLK), .pins(pins));
   pid_top dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .PINS(pins), .SRC(src), .MODE(mode),
      .SPEED(spd), .DOWN_CMD(dcmd), .INT_TICK(tick), .OTHER_MATCH(om), .STROBE(stb),
      .SPEED_ERR(serr), .INDEX(idx), .FUNC_IN(fin), .LATCH_IN(lin), .GP_A(gpa), .GP_B(gpb),
      .GP_A_VALID(gpav), .GP_B_VALID(gpbv));
   task automatic chk_bit(input string n, input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %b got %b", n, e, s);
      end
   endtask
   task automatic chk_stb(input pid_pkg::pid_strobe_s e, input pid_pkg::pid_strobe_s s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH STROBE exp %b got %b", e, s);
      end
   endtask
   task automatic test_done();
      chk_bit("queue_empty", 1'b1, q.size() == 0);
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   function automatic int gap(input pid_pkg::pid_spd_e s);
      case (s)
         pid_pkg::PID_SPD_10K: return int'(pid_pkg::GAP_10K);
         pid_pkg::PID_SPD_50K: return int'(pid_pkg::GAP_50K);
         pid_pkg::PID_SPD_100K: return int'(pid_pkg::GAP_100K);
         default: return int'(pid_pkg::GAP_200K);
      endcase
   endfunction
   // Works out the expected step from the previous and new A/B levels.
   function automatic pid_pkg::pid_strobe_s want(input logic pa, pb, a, b, d);
      logic ra, fa, rb, fb, up, dn;
      ra = a & ~pa;
      fa = pa & ~a;
      rb = b & ~pb;
      fb = pb & ~b;
      case (mode)
         pid_pkg::PID_MODE_UP_DOWN_PAIR: begin
            up = ra & ~b;
            dn = rb & ~a;
         end
         pid_pkg::PID_MODE_2P_X1: begin
            up = ra & ~b;
            dn = fa & ~b;
         end
         pid_pkg::PID_MODE_2P_X2: begin
            up = (ra & ~b) | (fa & b);
            dn = (ra & b) | (fa & ~b);
         end
         pid_pkg::PID_MODE_2P_X4: begin
            up = (ra & ~b) | (fa & b) | (rb & a) | (fb & ~a);
            dn = (ra & b) | (fa & ~b) | (rb & ~a) | (fb & a);
         end
         pid_pkg::PID_MODE_1P_X2: begin
            up = (ra | fa) & ~b & ~d;
            dn = (ra | fa) & (b | d);
         end
         default: begin
            up = (ra | fa) & ~d;
            dn = (ra | fa) & d;
         end
      endcase
      want = {up & ~dn, dn & ~up};
   endfunction
   // Moves the encoder one step and notes any expected strobe.
   task automatic move(input logic on_b);
      p = pins;
      enc.step(on_b, 3'($urandom));
      if (want(p.a, p.b, pins.a, pins.b, dcmd) != 2'b00) begin
         q.push_back(want(p.a, p.b, pins.a, pins.b, dcmd));
      end
   endtask
   task automatic setup(input pid_pkg::pid_mode_e m, input pid_pkg::pid_spd_e s);
      @(posedge SYS_CLK);
      #1;
      mode = m;
      spd = s;
      repeat (gap(s) + 10) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic run(input pid_pkg::pid_mode_e m, input pid_pkg::pid_spd_e s, input int n);
      setup(m, s);
      chk_bit("SPEED_ERR", 1'b0, serr);
      chk_bit("GP_B_VALID", m == pid_pkg::PID_MODE_1P_X2_A, gpbv);
      chk_bit("GP_A_VALID", 1'b0, gpav);
      for (int i = 0; i < n; i++) begin
         dcmd = 1'($urandom);
         move(1'($urandom));
         repeat (2) @(posedge SYS_CLK);
         #1;
         chk_bit("INDEX", pins.z, idx);
         chk_bit("FUNC_IN", pins.func, fin);
         chk_bit("LATCH_IN", pins.latch, lin);
         chk_bit("GP_A", pins.a, gpa);
         chk_bit("GP_B", pins.b, gpb);
         repeat (gap(s) + 8) @(posedge SYS_CLK);
         #1;
      end
   endtask
   task automatic bad(input pid_pkg::pid_mode_e m, input pid_pkg::pid_spd_e s);
      setup(m, s);
      chk_bit("SPEED_ERR", 1'b1, serr);
      repeat (4) enc.step(1'($urandom), 3'h0);
      repeat (4) @(posedge SYS_CLK);
   endtask
   always @(negedge SYS_CLK) begin
      if (RESET === 1'b0 && (stb.up === 1'b1 || stb.down === 1'b1)) begin
         if (q.size() == 0) begin
            chk_stb(2'b00, stb);
         end else begin
            chk_stb(q.pop_front(), stb);
         end
      end
   end
   initial begin
      SYS_CLK = 1'b0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      #396000;
      fail_count++;
      test_done();
   end
   initial begin
      {RESET, dcmd, tick, om} = 4'h8;
      src = pid_pkg::PID_SRC_AB;
      mode = pid_pkg::PID_MODE_2P_X4;
      spd = pid_pkg::PID_SPD_200K;
      void'($urandom(32'hA8E5));
      repeat (3) @(posedge SYS_CLK);
      #1;
      RESET = 1'b0;
      run(pid_pkg::PID_MODE_2P_X4, pid_pkg::PID_SPD_200K, 12);
      move(1'b0);
      enc.step(1'b1, 3'h0);
      run(pid_pkg::PID_MODE_2P_X2, pid_pkg::PID_SPD_100K, 6);
      run(pid_pkg::PID_MODE_2P_X1, pid_pkg::PID_SPD_50K, 4);
      run(pid_pkg::PID_MODE_UP_DOWN_PAIR, pid_pkg::PID_SPD_100K, 6);
      run(pid_pkg::PID_MODE_1P_X2_A, pid_pkg::PID_SPD_200K, 8);
      run(pid_pkg::PID_MODE_1P_X2, pid_pkg::PID_SPD_200K, 2);
      bad(pid_pkg::PID_MODE_2P_X1, pid_pkg::PID_SPD_100K);
      bad(pid_pkg::PID_MODE_2P_X2, pid_pkg::PID_SPD_200K);
      @(posedge SYS_CLK);
      #1;
      src = pid_pkg::PID_SRC_INT_1U;
      dcmd = 1'b0;
      enc.step(1'b0, 3'h0);
      chk_bit("GP_A_VALID", 1'b1, gpav);
      tick = 1'b1;
      q.push_back(2'b10);
      q.push_back(2'b10);
      repeat (2) @(posedge SYS_CLK);
      #1;
      tick = 1'b0;
      src = pid_pkg::PID_SRC_OTHER_CH;
      repeat (2) @(posedge SYS_CLK);
      #1;
      om = 1'b1;
      q.push_back(2'b10);
      repeat (6) @(posedge SYS_CLK);
      test_done();
   end
endmodule // test_pid_top
